// ===== rtl/fhp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module fhp_host_port
    import fhp_pkg::*;
#(
    parameter int unsigned ADDR_W = FHP_ADDR_W
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   bus_personality_select,
    input  wire logic                   cs_n,
    input  wire logic                   address_latch_strobe,
    input  wire logic                   read_strobe_n,
    input  wire logic                   write_strobe_n,
    input  wire logic [ADDR_W-1:0]      addr_in,
    input  wire logic [FHP_DATA_W-1:0]  data_in,
    output var  logic [FHP_DATA_W-1:0]  data_out,
    output var  logic                   data_oe,
    output var  logic                   transfer_ready_n,
    input  wire logic [FHP_NUM_CNT-1:0] count_event
);

    localparam int unsigned REG_DEPTH = 2 ** ADDR_W;
    localparam int unsigned SETTLE_W  = $clog2(FHP_RD_SETTLE_CYC + 1);

    // =========================================================
    // strap and strobe synchronisers
    logic        pers_q;
    fhp_strobe_t strb_s1_q;
    fhp_strobe_t strb_s2_q;
    fhp_strobe_t strb_s3_q;
    fhp_strobe_t strb_idle;

    // idle latch level follows the strap, else a false latch edge follows reset
    always_comb begin
        strb_idle     = FHP_STRB_IDLE;
        strb_idle.ale = bus_personality_select;
    end

    // strap is only meaningful while held in reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pers_q <= bus_personality_select;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            strb_s1_q <= strb_idle;
            strb_s2_q <= strb_idle;
            strb_s3_q <= strb_idle;
        end else begin
            strb_s1_q <= {address_latch_strobe, read_strobe_n, write_strobe_n};
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
        end
    end

    // =========================================================
    // personality decode
    logic rd_act;
    logic rd_prev;
    logic wr_act;
    logic wr_prev;
    logic ale_edge;

    always_comb begin
        if (pers_q == FHP_PERS_SEPARATE) begin
            rd_act   = !strb_s2_q.rd_n;
            rd_prev  = !strb_s3_q.rd_n;
            wr_act   = !strb_s2_q.wr_n;
            wr_prev  = !strb_s3_q.wr_n;
            ale_edge = !strb_s2_q.ale && strb_s3_q.ale;
        end else begin
            // data strobe qualified by the direction level
            rd_act   = !strb_s2_q.rd_n && strb_s2_q.wr_n;
            rd_prev  = !strb_s3_q.rd_n && strb_s3_q.wr_n;
            wr_act   = !strb_s2_q.rd_n && !strb_s2_q.wr_n;
            wr_prev  = !strb_s3_q.rd_n && !strb_s3_q.wr_n;
            ale_edge = strb_s2_q.ale && !strb_s3_q.ale;
        end
    end

    fhp_state_t state_q;
    logic       rd_start;
    logic       wr_start;
    logic       wr_commit;
    logic       access_end;

    assign rd_start   = rd_act && !rd_prev && !cs_n && (state_q == FHP_IDLE);
    assign wr_start   = wr_act && !wr_prev && !cs_n && (state_q == FHP_IDLE);
    assign wr_commit  = (state_q == FHP_WR_HOLD) && !wr_act;
    assign access_end = wr_commit || ((state_q == FHP_RD_HOLD) && !rd_act);

    // =========================================================
    // counter address decode
    function automatic fhp_cnt_sel_t cnt_decode(input logic [ADDR_W-1:0] a);
        fhp_cnt_sel_t s;
        s = '0;
        case (a)
            FHP_LCV_HIGH_ADDR:  s = '{valid: 1'b1, idx: 2'h0, low: 1'b0};
            FHP_LCV_LOW_ADDR:   s = '{valid: 1'b1, idx: 2'h0, low: 1'b1};
            FHP_FRM_HIGH_ADDR:  s = '{valid: 1'b1, idx: 2'h1, low: 1'b0};
            FHP_FRM_LOW_ADDR:   s = '{valid: 1'b1, idx: 2'h1, low: 1'b1};
            FHP_FAR_END_BLOCK_ERROR_HIGH_ADDR: s = '{valid: 1'b1, idx: 2'h2, low: 1'b0};
            FHP_FAR_END_BLOCK_ERROR_LOW_ADDR:  s = '{valid: 1'b1, idx: 2'h2, low: 1'b1};
            FHP_PAR_HIGH_ADDR:  s = '{valid: 1'b1, idx: 2'h3, low: 1'b0};
            FHP_PAR_LOW_ADDR:   s = '{valid: 1'b1, idx: 2'h3, low: 1'b1};
            default:            s = '0;
        endcase
        return s;
    endfunction

    // =========================================================
    // address latch and burst stepping
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        regs_q [REG_DEPTH];
    logic              burst_en;
    fhp_cnt_sel_t      cnt_sel;
    logic [7:0]        wdata_q;

    assign burst_en = regs_q[FHP_CTRL_ADDR][FHP_CTRL_BURST_BIT];
    assign cnt_sel  = cnt_decode(addr_q);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (ale_edge && !cs_n && (state_q == FHP_IDLE)) begin
            addr_q <= addr_in;
        end else if (access_end && burst_en) begin
            addr_q <= ADDR_W'(addr_q + 1'b1);
        end
    end

    // =========================================================
    // event counters and holding byte
    logic [FHP_CNT_W-1:0] cnt_q [FHP_NUM_CNT];
    logic [7:0]           hold_q;

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < FHP_NUM_CNT; i++) begin
            if (!resetn) begin
                cnt_q[i] <= FHP_CNT_RESET;
            end else if (rd_start && cnt_sel.valid && (cnt_sel.idx == 2'(i))) begin
                // an event in the clearing cycle is kept as the first count
                cnt_q[i] <= count_event[i] ? 16'h0001 : FHP_CNT_RESET;
            end else if (count_event[i] && (cnt_q[i] != FHP_CNT_MAX)) begin
                cnt_q[i] <= 16'(cnt_q[i] + 1'b1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hold_q <= FHP_REG_RESET;
        end else if (rd_start && cnt_sel.valid) begin
            // companion byte, whichever half was asked for
            hold_q <= cnt_sel.low ? cnt_q[cnt_sel.idx][15:8]
                                  : cnt_q[cnt_sel.idx][7:0];
        end
    end

    // =========================================================
    // byte register file
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < REG_DEPTH; i++) begin
                regs_q[i] <= FHP_REG_RESET;
            end
        end else if (wr_commit && !cnt_sel.valid && (addr_q != FHP_HOLD_ADDR)) begin
            regs_q[addr_q] <= wdata_q;
        end
    end

    logic [7:0] rdata;

    always_comb begin
        if (cnt_sel.valid) begin
            rdata = cnt_sel.low ? cnt_q[cnt_sel.idx][7:0]
                                : cnt_q[cnt_sel.idx][15:8];
        end else if (addr_q == FHP_HOLD_ADDR) begin
            rdata = hold_q;
        end else begin
            rdata = regs_q[addr_q];
        end
    end

    // =========================================================
    // transfer handshake
    logic [SETTLE_W-1:0] settle_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q          <= FHP_IDLE;
            settle_q         <= '0;
            data_out         <= FHP_REG_RESET;
            data_oe          <= 1'b0;
            transfer_ready_n <= 1'b1;
            wdata_q          <= FHP_REG_RESET;
        end else begin
            case (state_q)
                FHP_IDLE: begin
                    if (rd_start) begin
                        state_q  <= FHP_RD_SETTLE;
                        settle_q <= SETTLE_W'(FHP_RD_SETTLE_CYC - 1);
                        data_out <= rdata;
                        data_oe  <= 1'b1;
                    end else if (wr_start) begin
                        state_q <= FHP_WR_HOLD;
                        wdata_q <= data_in;
                    end
                end
                FHP_RD_SETTLE: begin
                    // ready held off for the settle time even if host quits early
                    if (settle_q == '0) begin
                        state_q          <= FHP_RD_HOLD;
                        transfer_ready_n <= 1'b0;
                    end else begin
                        settle_q <= SETTLE_W'(settle_q - 1'b1);
                    end
                end
                FHP_RD_HOLD: begin
                    if (!rd_act) begin
                        state_q          <= FHP_IDLE;
                        data_oe          <= 1'b0;
                        transfer_ready_n <= 1'b1;
                    end
                end
                FHP_WR_HOLD: begin
                    if (wr_act) begin
                        // keep tracking the bus so the last value before release lands
                        wdata_q          <= data_in;
                        transfer_ready_n <= 1'b0;
                    end else begin
                        state_q          <= FHP_IDLE;
                        transfer_ready_n <= 1'b1;
                    end
                end
                default: begin
                    state_q          <= FHP_IDLE;
                    data_oe          <= 1'b0;
                    transfer_ready_n <= 1'b1;
                end
            endcase
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_READ_ENABLES_BUS:
    assert property (rd_start |=> data_oe && (data_out == $past(rdata)))
        else $error("read did not drive addressed byte");

    AST_READY_AFTER_SETTLE:
    assert property (rd_start |=> transfer_ready_n [*2] ##1 !transfer_ready_n)
        else $error("read ready timing wrong");

    AST_BUS_RELEASE:
    assert property ((state_q == FHP_RD_HOLD) && !rd_act |=> !data_oe && transfer_ready_n)
        else $error("bus not released after read strobe");

    AST_HIGH_BYTE_MAP:
    assert property (rd_start && (addr_q == FHP_LCV_HIGH_ADDR)
                     |=> data_out == $past(cnt_q[0][15:8]))
        else $error("violation counter high byte wrong");

    AST_CLEAR_ON_READ:
    assert property (rd_start && cnt_sel.valid && (cnt_sel.idx == 2'h0) && !count_event[0]
                     |=> cnt_q[0] == FHP_CNT_RESET)
        else $error("counter not cleared by read");

    AST_HOLD_LOW_CAPTURE:
    assert property (rd_start && (addr_q == FHP_LCV_HIGH_ADDR)
                     |=> hold_q == $past(cnt_q[0][7:0]))
        else $error("holding register missed low byte");

    AST_HOLD_HIGH_CAPTURE:
    assert property (rd_start && (addr_q == FHP_LCV_LOW_ADDR)
                     |=> hold_q == $past(cnt_q[0][15:8]))
        else $error("holding register missed high byte");

    AST_CLEARED_HIGH_ZERO:
    assert property (rd_start && (addr_q == FHP_LCV_HIGH_ADDR) && (cnt_q[0] == FHP_CNT_RESET)
                     |=> data_out == 8'h00)
        else $error("cleared counter high byte not zero");

    AST_HOLD_STABLE:
    assert property (!(rd_start && cnt_sel.valid) |=> $stable(hold_q))
        else $error("holding register changed without counter read");

    AST_ADDR_LATCH:
    assert property (ale_edge && !cs_n && (state_q == FHP_IDLE) && !burst_en
                     |=> addr_q == $past(addr_in))
        else $error("address not latched on strobe edge");

    AST_WRITE_READY:
    assert property (wr_start ##1 wr_act |=> !transfer_ready_n)
        else $error("write ready not given");

    AST_WRITE_STORE:
    assert property (wr_commit && !cnt_sel.valid && (addr_q != FHP_HOLD_ADDR)
                     |=> regs_q[$past(addr_q)] == $past(wdata_q))
        else $error("write not stored on strobe release");

    AST_STROBE_TO_ACCESS:
    assert property ($fell(read_strobe_n) && !cs_n && (state_q == FHP_IDLE)
                     && (pers_q == FHP_PERS_SEPARATE) |-> ##2 rd_start ##1 !rd_start)
        else $error("read strobe edge did not give exactly one access");

    COV_COUNTER_PAIR:
    cover property (rd_start && cnt_sel.valid ##[1:40] rd_start && (addr_q == FHP_HOLD_ADDR));

    COV_WRITE:
    cover property (wr_start ##[1:40] wr_commit);

    COV_BURST:
    cover property (access_end && burst_en);

endmodule // fhp_host_port
`default_nettype wire

// ===== rtl/fhp_pkg.sv
// Summary of operation
// - plain registers are whole bytes, one access
// - even and odd addresses both reachable
// - four 16-bit event counters, high and low byte
// - violation counter high at 0x50, low 0x51
// - reading either counter byte clears whole counter
// - unread companion byte copied to holding register
// - high byte after low byte reads zero
// - either byte may be read first
// - single accesses plus burst transfer mode
// - address captured on latch strobe trailing edge
// - read strobe low enables data drivers
// - ready high until read data stable
// - write strobe low opens data input path
// - ready low once write data taken
// - register stored on write strobe release
// - data bus released when read strobe rises
// - master reset restores all defaults
package fhp_pkg;

    // =========================================================
    // sizes and map
    localparam int unsigned FHP_ADDR_W  = 9;
    localparam int unsigned FHP_DATA_W  = 8;
    localparam int unsigned FHP_CNT_W   = 16;
    localparam int unsigned FHP_NUM_CNT = 4;

    localparam logic [8:0] FHP_LCV_HIGH_ADDR  = 9'h050;
    localparam logic [8:0] FHP_LCV_LOW_ADDR   = 9'h051;
    localparam logic [8:0] FHP_FRM_HIGH_ADDR  = 9'h052;
    localparam logic [8:0] FHP_FRM_LOW_ADDR   = 9'h053;
    localparam logic [8:0] FHP_FAR_END_BLOCK_ERROR_HIGH_ADDR = 9'h054;
    localparam logic [8:0] FHP_FAR_END_BLOCK_ERROR_LOW_ADDR  = 9'h055;
    localparam logic [8:0] FHP_PAR_HIGH_ADDR  = 9'h056;
    localparam logic [8:0] FHP_PAR_LOW_ADDR   = 9'h057;
    localparam logic [8:0] FHP_HOLD_ADDR      = 9'h06c;
    localparam logic [8:0] FHP_CTRL_ADDR      = 9'h00e;
    localparam int unsigned FHP_CTRL_BURST_BIT = 0;

    // =========================================================
    // reset values and timing
    localparam logic [7:0]  FHP_REG_RESET  = 8'h00;
    localparam logic [15:0] FHP_CNT_RESET  = 16'h0000;
    localparam logic [15:0] FHP_CNT_MAX    = 16'hffff;
    localparam logic        FHP_PERS_SEPARATE = 1'b0;

    localparam int unsigned FHP_CLK_PERIOD_NS = 50;
    localparam int unsigned FHP_RD_SETTLE_NS  = 100;
    localparam int unsigned FHP_RD_SETTLE_CYC =
        (FHP_RD_SETTLE_NS + FHP_CLK_PERIOD_NS - 1) / FHP_CLK_PERIOD_NS;

    // =========================================================
    // types
    typedef enum logic [1:0] {
        FHP_IDLE      = 2'h0,
        FHP_RD_SETTLE = 2'h1,
        FHP_RD_HOLD   = 2'h3,
        FHP_WR_HOLD   = 2'h2
    } fhp_state_t;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
    } fhp_strobe_t;

    localparam fhp_strobe_t FHP_STRB_IDLE = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

    typedef struct packed {
        logic       valid;
        logic [1:0] idx;
        logic       low;
    } fhp_cnt_sel_t;

endpackage

// ===== verif/fhp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhp_host_model
    import fhp_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  transfer_ready_n,
    input  wire logic [FHP_DATA_W-1:0] bus,
    input  wire logic                  bus_personality_select,
    input  wire logic                  skip_latch,
    output var  logic                  cs_n,
    output var  logic                  ale,
    output var  logic                  rd_n,
    output var  logic                  wr_n,
    output var  logic [FHP_ADDR_W-1:0] addr,
    output var  logic [FHP_DATA_W-1:0] host_d
);
    initial begin
        cs_n = 1'b1;
        ale = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = '0;
        host_d = 8'h00;
    end

    // =========================================================
    // one programmed access; ok stays low when no ready came
    task automatic access(input logic sel, input logic wr, input logic [8:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        @(negedge sys_clk);
        cs_n = ~sel;
        addr = a;
        // latch pulse polarity follows the personality; skipped for burst steps
        ale = bus_personality_select ^ !skip_latch;
        @(negedge sys_clk);
        ale = bus_personality_select;
        // address held until the synchronised latch edge is seen
        repeat (3) @(negedge sys_clk);
        host_d = d;
        @(negedge sys_clk);
        // data-strobe personality: rd_n is the strobe, wr_n the direction
        rd_n = wr && !bus_personality_select;
        wr_n = ~wr;
        n = 0;
        ok = 1'b0;
        while (n < 20 && !ok) begin
            @(posedge sys_clk);
            ok = (transfer_ready_n === 1'b0);
            n++;
        end
        q = bus;
        @(negedge sys_clk);
        rd_n = 1'b1;
        wr_n = 1'b1;
        n = 0;
        while (n < 20 && transfer_ready_n !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
        cs_n = 1'b1;
        // released lines show a changed pattern, never the last value
        host_d = ~d;
        addr = ~a;
    endtask
endmodule // fhp_host_model
`default_nettype wire

// ===== verif/tb_framer_host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_framer_host_bus_port;
    import fhp_pkg::*;
    logic       sys_clk, resetn, strap, cs_n, ale, rd_n, wr_n, data_oe, ready_n;
    logic [8:0] addr;
    logic [7:0] data_out, host_d, bus, q;
    logic [3:0] count_event;
    logic       ok;
    logic       skip_latch;
    int         fail_count, tests_run, cycles;
    int         cnt [4];
    int         hold;
    logic [7:0] mem [512];
    logic [8:0] alist [8];

    assign bus = data_oe ? data_out : host_d;

    fhp_host_port dut (.sys_clk(sys_clk), .resetn(resetn), .bus_personality_select(strap),
        .cs_n(cs_n), .address_latch_strobe(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .addr_in(addr), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
        .transfer_ready_n(ready_n), .count_event(count_event));
    fhp_host_model host (.sys_clk(sys_clk), .transfer_ready_n(ready_n), .bus(bus),
        .bus_personality_select(strap), .skip_latch(skip_latch),
        .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .host_d(host_d));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // =========================================================
    // checking and reference model
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] model_rd(input logic [8:0] a);
        int i;
        logic [15:0] c;
        i = int'(a[2:1]);
        if (a >= FHP_LCV_HIGH_ADDR && a <= FHP_PAR_LOW_ADDR) begin
            c = cnt[i][15:0];
            cnt[i] = 0;
            hold = a[0] ? c[15:8] : c[7:0];
            return a[0] ? c[7:0] : c[15:8];
        end
        if (a == FHP_HOLD_ADDR) return hold[7:0];
        return mem[a];
    endfunction

    task automatic rdc(input logic [8:0] a);
        logic [7:0] exp;
        exp = model_rd(a);
        host.access(1'b1, 1'b0, a, ~exp, q, ok);
        check_bit(ok, 1'b1);
        check_byte(q, exp);
        check_bit(data_oe, 1'b0);
    endtask

    task automatic wrc(input logic sel, input logic [8:0] a, input logic [7:0] d);
        host.access(sel, 1'b1, a, d, q, ok);
        check_bit(ok, sel);
        if (sel && !(a >= FHP_LCV_HIGH_ADDR && a <= FHP_PAR_LOW_ADDR) && a != FHP_HOLD_ADDR)
            mem[a] = d;
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            count_event = 4'($urandom);
            for (int j = 0; j < 4; j++) cnt[j] += int'(count_event[j]);
        end
        @(negedge sys_clk);
        count_event = 4'h0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        foreach (mem[k]) mem[k] = FHP_REG_RESET;
        foreach (cnt[k]) cnt[k] = 0;
        hold = 0;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the whole run needs roughly one to one and a half thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // =========================================================
    // tests
    initial begin
        strap = FHP_PERS_SEPARATE;
        resetn = 1'b0;
        count_event = 4'h0;
        fail_count = 0;
        skip_latch = 1'b0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(98211));
        do_reset();
        rdc(9'h000);
        rdc(FHP_LCV_LOW_ADDR);
        rdc(FHP_HOLD_ADDR);
        $display("test reset_values done");
        for (int k = 0; k < 8; k++) begin
            alist[k] = {1'b1, 7'($urandom), k[0]};
            wrc(1'b1, alist[k], 8'($urandom));
        end
        for (int k = 0; k < 8; k++) rdc(alist[k]);
        $display("test plain_regs done");
        pulse($urandom_range(40, 300));
        for (int i = 0; i < 4; i++) begin
            rdc(FHP_LCV_HIGH_ADDR + 9'(2 * i + i % 2));
            rdc(FHP_HOLD_ADDR);
            rdc(FHP_HOLD_ADDR);
            rdc(FHP_LCV_HIGH_ADDR + 9'(2 * i + 1 - i % 2));
        end
        $display("test counters done");
        pulse(30);
        wrc(1'b1, FHP_LCV_LOW_ADDR, 8'ha5);
        wrc(1'b1, FHP_HOLD_ADDR, 8'h5a);
        wrc(1'b0, alist[0], ~mem[alist[0]]);
        rdc(alist[0]);
        rdc(FHP_HOLD_ADDR);
        rdc(FHP_FRM_LOW_ADDR);
        rdc(FHP_LCV_LOW_ADDR);
        rdc(FHP_HOLD_ADDR);
        $display("test refusals done");
        wrc(1'b1, FHP_CTRL_ADDR, 8'h01);
        wrc(1'b1, 9'h020, 8'h11);
        skip_latch = 1'b1;
        wrc(1'b1, 9'h021, 8'h22);
        rdc(9'h022);
        skip_latch = 1'b0;
        wrc(1'b1, FHP_CTRL_ADDR, 8'h00);
        rdc(9'h020);
        rdc(9'h021);
        $display("test burst done");
        wrc(1'b1, alist[1], 8'h3c);
        pulse(25);
        do_reset();
        rdc(alist[1]);
        rdc(FHP_PAR_HIGH_ADDR);
        rdc(FHP_HOLD_ADDR);
        $display("test mid_reset done");
        strap = 1'b1;
        do_reset();
        wrc(1'b1, alist[3], 8'h96);
        rdc(alist[3]);
        pulse(20);
        rdc(FHP_FAR_END_BLOCK_ERROR_LOW_ADDR);
        rdc(FHP_HOLD_ADDR);
        $display("test data_strobe done");
        final_report();
    end
endmodule // tb_framer_host_bus_port
`default_nettype wire
